// File: cspc_card.sv
/* card in the socket: accesses on request, counts card clock edges.
   assumes the bench drives go. */
module cspc_card (
	input  wire logic clk,rst_n,clk_en,go,
	output logic      access,
	output int        edges
);
	timeunit 1ns;
	timeprecision 1ns;
	// card acts only on an enabled card clock edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			access <= 1'b0;
			edges  <= 0;
		end else begin
			access <= go && clk_en;
			edges  <= edges + clk_en;
		end
	end
endmodule

// File: cspc_chk_properties.sv
/* port checker for cspc_top.
   assumes one clock and the async low global reset. */
module cspc_chk
	import cspc_pkg::*;
#(parameter int IDLE_QUAL = IDLE_CYCLES) (
	input wire logic CORE_CLK_I,RST_N_I,PRST_N_I,REG_SEL_I,REG_WR_I,REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,REG_RDATA_O,
	input wire logic REG_ACK_O,CARD_ACCESS_I,SOCKET_IDLE_I,CARD_CLK_EN_O,
	input wire logic CLK_MODE_SLOW_O,CLK_MODE_STOP_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// short aliases of the mode and card clock enable outputs
	wire logic sl = CLK_MODE_SLOW_O;
	wire logic st = CLK_MODE_STOP_O;
	wire logic ce = CARD_CLK_EN_O;
	wire logic nc = !ce || !sl;
	a_ack_one_later: assert property (REG_ACK_O == $past(REG_SEL_I)) else $error("ack");
	a_rsvd_read_zero: assert property (REG_ACK_O |-> !(REG_RDATA_O & 32'hFCFE_FFFE))
		else $error("reserved");
	a_unmapped_zero: assert property (REG_SEL_I && REG_RD_I && REG_ADDR_I != SPM_OFFSET
		|=> REG_RDATA_O == 32'h0) else $error("unmapped");
	a_run_clk_on: assert property (!sl && !st |=> ce) else $error("run");
	a_stop_clk_off: assert property (st ##1 st |-> !ce) else $error("stop");
	a_one_mode: assert property (!(sl && st)) else $error("modes");
	a_slow_div_16: assert property (ce && sl && $past(sl) |=> nc[*8] ##1 nc[*7]
		##1 (ce || !sl)) else $error("slow");
	a_idle_before: assert property ($rose(sl || st) |-> $past(SOCKET_IDLE_I, 4))
		else $error("idle");
	a_busy_runs: assert property (!SOCKET_IDLE_I[*5] |-> !sl && !st) else $error("busy");
	cover property (st);
	cover property (sl && ce);
	cover property (REG_ACK_O && REG_RDATA_O[25]);
endmodule
bind cspc_top cspc_chk #(.IDLE_QUAL(IDLE_QUAL)) u_chk (.*);

// File: cspc_pkg.sv
/*
 * package for the card socket clock/power control block: register layout,
 * field positions, reset values, timing counts and carrier types.
 * assumes a single 10 MHz core clock domain.
 */
package cspc_pkg;

	// register offset within the socket register space
	localparam logic [7:0]  SPM_OFFSET         = 8'h20;
	// field positions
	localparam int          ACCESS_FLAG_BIT    = 25;
	localparam int          CLK_CHANGED_BIT    = 24;
	localparam int          CTL_ENABLE_BIT     = 16;
	localparam int          STOP_SLOW_BIT      = 0;
	localparam logic [31:0] SPM_RESET          = 32'h0000_0000;
	// writable bits mask
	localparam logic [31:0] SPM_WMASK          = 32'h0001_0001;
	// slow divide factor and idle qualification
	localparam int          SLOW_DIV           = 16;
	localparam int          DIV_W              = 4;
	localparam int          IDLE_CYCLES        = 8;
	localparam int          IDLE_W             = 4;

	typedef enum logic [1:0] {
		CK_RUN  = 2'b00,
		CK_STOP = 2'b01,
		CK_SLOW = 2'b10
	} cspc_clk_mode_t;

	// register bus request carrier
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} cspc_req_t;

endpackage

// File: cspc_top.sv
/*
 * socket power management register and idle-time card clock control.
 * holds the one 32-bit register with its two sticky status flags, the two
 * writable control bits, the idle qualification counter and the card clock
 * enable generator that stops or slows the card clock while the socket idles.
 * every selected request is answered one cycle later by a one-cycle
 * acknowledge; read data is registered and holds until the next read.
 * unmapped offsets are acknowledged as well, read as zero and drop writes.
 * the clock-run machinery leaves the run mode only when the enable is set,
 * the socket has been idle for the qualification time and no card access
 * is seen; any access or the end of idle returns it to run at once.
 * assumes register requests come from same-clock logic; the card activity
 * and socket idle inputs arrive from outside and are synchronised here.
 * the global reset is the async RST_N_I; PRST_N_I is a lesser reset.
 * assumes the card clock itself is gated downstream by CARD_CLK_EN_O,
 * one allowed card clock edge per core cycle in which the enable is high.
 * assumes IDLE_QUAL stays below the range of the idle counter.
 */
module cspc_top
	import cspc_pkg::*;
#(
	parameter int IDLE_QUAL = IDLE_CYCLES
) (
	// clock and resets
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PRST_N_I,
	// register bus, same clock domain
	input  wire logic        REG_SEL_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	output logic      [31:0] REG_RDATA_O,
	output logic             REG_ACK_O,
	// card side, asynchronous inputs
	input  wire logic        CARD_ACCESS_I,
	input  wire logic        SOCKET_IDLE_I,
	output logic             CARD_CLK_EN_O,
	output logic             CLK_MODE_SLOW_O,
	output logic             CLK_MODE_STOP_O
);

	typedef struct packed {
		// input synchronisers, first stage read only by the second
		logic              acc_s1;
		logic              acc_s2;
		logic              idle_s1;
		logic              idle_s2;
		logic              prst_s1;
		logic              prst_s2;
		// register contents
		logic              access_flag;
		logic              clk_changed;
		logic              ctl_enable;
		logic              stop_or_slow;
		// clock-run machinery
		logic [IDLE_W-1:0] idle_cnt;
		logic [DIV_W-1:0]  div_cnt;
		cspc_clk_mode_t    mode;
		logic              clk_en;
		// bus answer
		logic [31:0]       rdata;
		logic              ack;
	} cspc_state_t;

	// registered state and its next value
	cspc_state_t st_ff;
	cspc_state_t nxt_st;
	// working nets
	cspc_req_t   req;
	logic        hit;
	logic        idle_ok;

	// bundle the bus request
	assign req = '{
		sel:   REG_SEL_I,
		wr:    REG_WR_I,
		rd:    REG_RD_I,
		addr:  REG_ADDR_I,
		wdata: REG_WDATA_I
	};
	// only the one offset is mapped
	assign hit = req.sel && (req.addr == SPM_OFFSET);
	// socket idle long enough to act on
	assign idle_ok = (32'(st_ff.idle_cnt) >= IDLE_QUAL);

	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;

		// two-flop synchronisers of the outside inputs
		nxt_st.acc_s1 = CARD_ACCESS_I;
		nxt_st.acc_s2 = st_ff.acc_s1;
		nxt_st.idle_s1 = SOCKET_IDLE_I;
		nxt_st.idle_s2 = st_ff.idle_s1;
		nxt_st.prst_s1 = PRST_N_I;
		nxt_st.prst_s2 = st_ff.prst_s1;

		// register access, read wins when both qualifiers are high
		if (hit && req.rd) begin
			// reserved ranges always read zero
			nxt_st.rdata = 32'h0000_0000;
			nxt_st.rdata[ACCESS_FLAG_BIT] = st_ff.access_flag;
			nxt_st.rdata[CLK_CHANGED_BIT] = st_ff.clk_changed;
			nxt_st.rdata[CTL_ENABLE_BIT] = st_ff.ctl_enable;
			nxt_st.rdata[STOP_SLOW_BIT] = st_ff.stop_or_slow;
			nxt_st.access_flag = 1'b0;
			nxt_st.ack = 1'b1;
		end else if (hit && req.wr) begin
			// only the two control bits are stored
			nxt_st.ctl_enable = req.wdata[CTL_ENABLE_BIT];
			nxt_st.stop_or_slow = req.wdata[STOP_SLOW_BIT];
			nxt_st.ack = 1'b1;
		end else if (req.sel) begin
			// unmapped: reads give zero, writes are dropped
			if (req.rd) begin
				nxt_st.rdata = 32'h0000_0000;
			end
			nxt_st.ack = 1'b1;
		end

		// access set wins over read clear
		// a read in the same cycle still reports the old flag value
		if (st_ff.acc_s2) begin
			nxt_st.access_flag = 1'b1;
		end

		// lesser reset clears control bits, not status flags
		if (!st_ff.prst_s2) begin
			nxt_st.ctl_enable = 1'b0;
			nxt_st.stop_or_slow = 1'b0;
		end

		// idle qualification counter
		// any card access restarts the count so a busy card keeps its clock
		if (!st_ff.idle_s2 || st_ff.acc_s2) begin
			nxt_st.idle_cnt = '0;
		end else if (!idle_ok) begin
			nxt_st.idle_cnt = st_ff.idle_cnt + IDLE_W'(1);
		end

		// clock-run mode selection
		// the enable gates everything, so the select alone never acts
		if (!st_ff.ctl_enable || !st_ff.idle_s2 || st_ff.acc_s2) begin
			nxt_st.mode = CK_RUN;
		end else if (idle_ok && st_ff.stop_or_slow) begin
			nxt_st.mode = CK_SLOW;
		end else if (idle_ok) begin
			nxt_st.mode = CK_STOP;
		end

		// card clock enable generation
		// slow allows one edge in sixteen; run restarts the divider
		case (st_ff.mode)
			CK_RUN: begin
				nxt_st.clk_en = 1'b1;
				nxt_st.div_cnt = '0;
			end
			CK_STOP: begin
				nxt_st.clk_en = 1'b0;
			end
			CK_SLOW: begin
				nxt_st.div_cnt = st_ff.div_cnt + DIV_W'(1);
				nxt_st.clk_en = (st_ff.div_cnt == DIV_W'(SLOW_DIV - 1));
			end
			default: begin
				nxt_st.clk_en = 1'b1;
			end
		endcase

		// rate changed flag, sticky until global reset
		// the lesser reset leaves it alone
		if (st_ff.mode != CK_RUN) begin
			nxt_st.clk_changed = 1'b1;
		end
	end

	// state register, global reset only
	// lesser reset synchroniser idles high so release does not fire it
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_ff <= '{
				mode:    CK_RUN,
				clk_en:  1'b1,
				prst_s1: 1'b1,
				prst_s2: 1'b1,
				default: '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// register bus outputs
	assign REG_RDATA_O = st_ff.rdata;
	assign REG_ACK_O = st_ff.ack;

	// card clock enable straight from its flip-flop
	assign CARD_CLK_EN_O = st_ff.clk_en;

	// mode status decoded from the registered mode
	assign CLK_MODE_SLOW_O = (st_ff.mode == CK_SLOW);
	assign CLK_MODE_STOP_O = (st_ff.mode == CK_STOP);

endmodule

// File: cspc_top_tb.sv
/* self-checking bench for cspc_top.
   assumes cspc_card and the bound checker. */
module cspc_top_tb;
	import cspc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic c=0,r=0,pr=1,sel=0,wr=0,rd=0,idle=0,go=0,ac,en,ack,slow,stop;
	logic [7:0] ad=0;
	logic [31:0] wd=0,q,rdat,d;
	int ed,e0,n_errors=0,checked=0;
	cspc_top #(.IDLE_QUAL(2)) DUT (.CORE_CLK_I(c),.RST_N_I(r),.PRST_N_I(pr),
		.REG_SEL_I(sel),.REG_WR_I(wr),.REG_RD_I(rd),.REG_ADDR_I(ad),.REG_WDATA_I(wd),
		.REG_RDATA_O(rdat),.REG_ACK_O(ack),.CARD_ACCESS_I(ac),.SOCKET_IDLE_I(idle),
		.CARD_CLK_EN_O(en),.CLK_MODE_SLOW_O(slow),.CLK_MODE_STOP_O(stop));
	cspc_card card (.clk(c),.rst_n(r),.clk_en(en),.go(go),.access(ac),.edges(ed));
	initial forever #50 c = ~c;
	task cmp(input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task t(input int n);
		repeat (n) @(posedge c);
		#10;
	endtask
	// one-cycle request, data taken with the ack
	task op(input logic w, input logic [7:0] a, input logic [31:0] v);
		t(1);
		{sel,wr,rd,ad,wd} = {1'b1,w,!w,a,v};
		t(1);
		sel = 0;
		q = rdat;
		cmp(1, ack);
	endtask
	task cnt(input int n, e);
		e0 = ed;
		t(n);
		cmp(e, ed - e0);
	endtask
	task conclude;
		if (n_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		conclude;
	end
	initial begin
		d = $urandom(32'he33c);
		d = $urandom;
		t(10);
		r = 1;
		op(0, SPM_OFFSET, 0); cmp(SPM_RESET, q);
		op(1, SPM_OFFSET, d); op(0, SPM_OFFSET, 0); cmp(d & SPM_WMASK, q);
		op(0, 8'h24, 0); cmp(0, q);
		op(1, SPM_OFFSET, 0);
		go = 1;
		t(3);
		go = 0;
		t(4);
		op(0, SPM_OFFSET, 0); cmp(32'h0200_0000, q);
		op(0, SPM_OFFSET, 0); cmp(0, q);
		op(1, SPM_OFFSET, 32'h0001_0000);
		idle = 1;
		t(10);
		cnt(16, 0);
		cmp(32'h1, {slow,stop});
		op(0, SPM_OFFSET, 0); cmp(32'h0101_0000, q);
		idle = 0;
		t(6);
		cnt(8, 8);
		cmp(32'h0, {slow,stop});
		op(1, SPM_OFFSET, 32'h0001_0001);
		idle = 1;
		t(10);
		cnt(32, 2);
		cmp(32'h2, {slow,stop});
		pr = 0;
		t(5);
		pr = 1;
		t(3);
		op(0, SPM_OFFSET, 0); cmp(32'h0100_0000, q);
		op(1, SPM_OFFSET, 1);
		cnt(16, 16);
		cmp(32'h0, {slow,stop});
		conclude;
	end
endmodule
